// *** design/ptu_pkg.sv ***
/*
 Program transfer unit package: register map, command and condition codes,
 field positions, reset values and the state carrier.
 Assumes a 32-bit APB register bus and 16-bit processor words.
*/
package ptu_pkg;
    // ==================================================================
    // Register map (byte addresses)
    localparam logic [7:0] OFS_CMD    = 8'h00;
    localparam logic [7:0] OFS_OPA    = 8'h04;
    localparam logic [7:0] OFS_OPB    = 8'h08;
    localparam logic [7:0] OFS_POPV   = 8'h0c;
    localparam logic [7:0] OFS_FLAGS  = 8'h10;
    localparam logic [7:0] OFS_IP     = 8'h14;
    localparam logic [7:0] OFS_CS     = 8'h18;
    localparam logic [7:0] OFS_SP     = 8'h1c;
    localparam logic [7:0] OFS_SS     = 8'h20;
    localparam logic [7:0] OFS_STATUS = 8'h24;

    // ==================================================================
    // Field positions
    localparam int CMD_OP_LSB   = 0;
    localparam int CMD_COND_LSB = 4;
    localparam int CMD_LEN_LSB  = 12;
    localparam int FLG_CARRY    = 0;
    localparam int FLG_ZERO     = 1;
    localparam int FLG_SIGN     = 2;
    localparam int FLG_OVF      = 3;
    localparam int FLG_PARITY   = 4;
    localparam int STS_BUSY     = 0;
    localparam int STS_TAKEN    = 1;
    localparam int STS_ERR      = 2;

    // ==================================================================
    // Reset values and constants
    localparam logic [15:0] IP_RST    = 16'h0000;
    localparam logic [15:0] CS_RST    = 16'h0000;
    localparam logic [15:0] SP_RST    = 16'h0000;
    localparam logic [15:0] SS_RST    = 16'h0000;
    localparam logic [15:0] WORD_STEP = 16'h0002;
    localparam logic [4:0]  COND_LAST = 5'h11;

    // ==================================================================
    // Conditional jump codes
    localparam logic [4:0] C_ABOVE = 5'h00;
    localparam logic [4:0] C_AE    = 5'h01;
    localparam logic [4:0] C_BELOW = 5'h02;
    localparam logic [4:0] C_BE    = 5'h03;
    localparam logic [4:0] C_CARRY = 5'h04;
    localparam logic [4:0] C_ZERO  = 5'h05;
    localparam logic [4:0] C_GT    = 5'h06;
    localparam logic [4:0] C_GE    = 5'h07;
    localparam logic [4:0] C_LT    = 5'h08;
    localparam logic [4:0] C_LE    = 5'h09;
    localparam logic [4:0] C_NCAR  = 5'h0a;
    localparam logic [4:0] C_NZERO = 5'h0b;
    localparam logic [4:0] C_NOVF  = 5'h0c;
    localparam logic [4:0] C_PODD  = 5'h0d;
    localparam logic [4:0] C_NSIGN = 5'h0e;
    localparam logic [4:0] C_OVF   = 5'h0f;
    localparam logic [4:0] C_PEVEN = 5'h10;
    localparam logic [4:0] C_SIGN  = 5'h11;

    // ==================================================================
    // Commands and states
    typedef enum logic [3:0] {
        PTU_NOP       = 4'h0,
        PTU_CALL_REL  = 4'h1,
        PTU_CALL_IND  = 4'h2,
        PTU_CALL_FAR  = 4'h3,
        PTU_CALL_FIND = 4'h4,
        PTU_RET_NEAR  = 4'h5,
        PTU_RET_FAR   = 4'h6,
        PTU_JMP_SHORT = 4'h7,
        PTU_JMP_NEAR  = 4'h8,
        PTU_JMP_IND   = 4'h9,
        PTU_JMP_FAR   = 4'ha,
        PTU_JMP_FIND  = 4'hb,
        PTU_JCC       = 4'hc
    } ptu_cmd_type;

    typedef enum logic [2:0] {
        PTU_IDLE    = 3'h0,
        PTU_PUSH_CS = 3'h1,
        PTU_PUSH_IP = 3'h2,
        PTU_POP_IP  = 3'h3,
        PTU_POP_CS  = 3'h4
    } ptu_state_type;

    // ==================================================================
    // Whole state of the unit
    typedef struct packed {
        ptu_state_type st;
        ptu_cmd_type   cmd;
        logic [15:0]   ip;
        logic [15:0]   cs;
        logic [15:0]   sp;
        logic [15:0]   ss;
        logic [15:0]   opa;
        logic [15:0]   opb;
        logic [15:0]   popv;
        logic [4:0]    flags;
        logic [15:0]   tgt_ip;
        logic [15:0]   tgt_cs;
        logic          busy;
        logic          taken;
        logic          err;
        logic [31:0]   prdata;
        logic          pready;
        logic          pslverr;
        logic          stk_req;
        logic          stk_we;
        logic [19:0]   stk_addr;
        logic [15:0]   stk_wdata;
        logic          flush;
        logic [19:0]   fetch_addr;
    } ptu_state_t_type;
endpackage : ptu_pkg

// *** design/ptu_program_transfer.sv ***
/*
 Program transfer unit: calls, returns, jumps and conditional jumps.
 Assumes an APB master for commands and a bus interface unit on the same
 clock that answers stack requests with stk_ack and refills the queue on flush.
*/
// Our own choices: register access over APB and the address map.
`timescale 1ns/1ps
module ptu_program_transfer (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             stk_req,
    output logic             stk_we,
    output logic      [19:0] stk_addr,
    output logic      [15:0] stk_wdata,
    input  wire logic [15:0] stk_rdata,
    input  wire logic        stk_ack,
    output logic             flush,
    output logic      [19:0] fetch_addr,
    output logic             busy
);
    // ==================================================================
    // Helpers
    function automatic logic [19:0] phys(input logic [15:0] seg, input logic [15:0] off);
        phys = {seg, 4'h0} + {4'h0, off};
    endfunction : phys

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a <= ptu_pkg::OFS_STATUS) && (a[1:0] == 2'b00);
    endfunction : mapped

    function automatic logic cond_ok(input logic [4:0] c, input logic [4:0] f);
        logic cy;
        logic zr;
        logic sg;
        logic ov;
        logic pa;
        cy = f[ptu_pkg::FLG_CARRY];
        zr = f[ptu_pkg::FLG_ZERO];
        sg = f[ptu_pkg::FLG_SIGN];
        ov = f[ptu_pkg::FLG_OVF];
        pa = f[ptu_pkg::FLG_PARITY];
        unique case (c)
            ptu_pkg::C_ABOVE: cond_ok = !(cy | zr);
            ptu_pkg::C_AE:    cond_ok = !cy;
            ptu_pkg::C_BELOW: cond_ok = cy;
            ptu_pkg::C_BE:    cond_ok = cy | zr;
            ptu_pkg::C_GT:    cond_ok = !((sg ^ ov) | zr);
            ptu_pkg::C_GE:    cond_ok = !(sg ^ ov);
            ptu_pkg::C_LT:    cond_ok = sg ^ ov;
            ptu_pkg::C_LE:    cond_ok = (sg ^ ov) | zr;
            ptu_pkg::C_CARRY: cond_ok = cy;
            ptu_pkg::C_NCAR:  cond_ok = !cy;
            ptu_pkg::C_ZERO:  cond_ok = zr;
            ptu_pkg::C_NZERO: cond_ok = !zr;
            ptu_pkg::C_OVF:   cond_ok = ov;
            ptu_pkg::C_NOVF:  cond_ok = !ov;
            ptu_pkg::C_PEVEN: cond_ok = pa;
            ptu_pkg::C_PODD:  cond_ok = !pa;
            ptu_pkg::C_SIGN:  cond_ok = sg;
            ptu_pkg::C_NSIGN: cond_ok = !sg;
            default:          cond_ok = 1'b0;
        endcase
    endfunction : cond_ok

    // ==================================================================
    // State and decode
    ptu_pkg::ptu_state_t_type q;
    ptu_pkg::ptu_state_t_type d;
    logic                     go;
    ptu_pkg::ptu_cmd_type     go_cmd;
    logic [4:0]               go_cond;
    logic [15:0]              nip;
    logic                     fin;
    logic [15:0]              fin_ip;
    logic [15:0]              fin_cs;

    // Command word fields and address of the following instruction
    assign go_cmd  = ptu_pkg::ptu_cmd_type'(pwdata[ptu_pkg::CMD_OP_LSB +: 4]);
    assign go_cond = pwdata[ptu_pkg::CMD_COND_LSB +: 5];
    assign nip     = q.ip + {12'h000, pwdata[ptu_pkg::CMD_LEN_LSB +: 4]};
    assign go      = psel && penable && q.pready && pwrite && !q.pslverr
                     && (paddr == ptu_pkg::OFS_CMD);

    // ==================================================================
    // Next-state logic
    always_comb begin
        d        = q;
        d.pready = 1'b0;
        d.flush  = 1'b0;
        fin      = 1'b0;
        fin_ip   = q.ip;
        fin_cs   = q.cs;
        // APB setup phase: answer prepared for the access phase
        if (psel && !penable) begin
            d.pready  = 1'b1;
            d.pslverr = !mapped(paddr)
                        || (pwrite && (q.busy || paddr == ptu_pkg::OFS_STATUS));
            unique case (paddr)
                ptu_pkg::OFS_OPA:    d.prdata = {16'h0000, q.opa};
                ptu_pkg::OFS_OPB:    d.prdata = {16'h0000, q.opb};
                ptu_pkg::OFS_POPV:   d.prdata = {16'h0000, q.popv};
                ptu_pkg::OFS_FLAGS:  d.prdata = {27'h0000000, q.flags};
                ptu_pkg::OFS_IP:     d.prdata = {16'h0000, q.ip};
                ptu_pkg::OFS_CS:     d.prdata = {16'h0000, q.cs};
                ptu_pkg::OFS_SP:     d.prdata = {16'h0000, q.sp};
                ptu_pkg::OFS_SS:     d.prdata = {16'h0000, q.ss};
                ptu_pkg::OFS_STATUS: d.prdata = {29'h00000000, q.err, q.taken, q.busy};
                default:             d.prdata = 32'h00000000;
            endcase
        end
        // APB access phase: register writes, refused while busy
        if (psel && penable && q.pready && pwrite && !q.pslverr) begin
            unique case (paddr)
                ptu_pkg::OFS_OPA:   d.opa   = pwdata[15:0];
                ptu_pkg::OFS_OPB:   d.opb   = pwdata[15:0];
                ptu_pkg::OFS_POPV:  d.popv  = pwdata[15:0];
                ptu_pkg::OFS_FLAGS: d.flags = pwdata[4:0];
                ptu_pkg::OFS_IP:    d.ip    = pwdata[15:0];
                ptu_pkg::OFS_CS:    d.cs    = pwdata[15:0];
                ptu_pkg::OFS_SP:    d.sp    = pwdata[15:0];
                ptu_pkg::OFS_SS:    d.ss    = pwdata[15:0];
                default:            d.err   = q.err;
            endcase
        end
        // Transfer sequencer
        unique case (q.st)
            ptu_pkg::PTU_IDLE: begin
                if (go) begin
                    d.cmd    = go_cmd;
                    d.ip     = nip;
                    d.err    = 1'b0;
                    d.taken  = 1'b0;
                    d.tgt_cs = q.cs;
                    d.tgt_ip = nip + q.opa;
                    if (go_cmd == ptu_pkg::PTU_JMP_SHORT || go_cmd == ptu_pkg::PTU_JCC) begin
                        d.tgt_ip = nip + {{8{q.opa[7]}}, q.opa[7:0]};
                    end
                    if (go_cmd == ptu_pkg::PTU_CALL_IND || go_cmd == ptu_pkg::PTU_JMP_IND) begin
                        d.tgt_ip = q.opa;
                    end
                    if (go_cmd == ptu_pkg::PTU_CALL_FAR || go_cmd == ptu_pkg::PTU_CALL_FIND
                        || go_cmd == ptu_pkg::PTU_JMP_FAR || go_cmd == ptu_pkg::PTU_JMP_FIND) begin
                        d.tgt_ip = q.opa;
                        d.tgt_cs = q.opb;
                    end
                    unique case (go_cmd)
                        ptu_pkg::PTU_CALL_FAR, ptu_pkg::PTU_CALL_FIND: begin
                            d.sp        = q.sp - ptu_pkg::WORD_STEP;
                            d.stk_addr  = phys(q.ss, q.sp - ptu_pkg::WORD_STEP);
                            d.stk_wdata = q.cs;
                            d.stk_we    = 1'b1;
                            d.stk_req   = 1'b1;
                            d.busy      = 1'b1;
                            d.st        = ptu_pkg::PTU_PUSH_CS;
                        end
                        ptu_pkg::PTU_CALL_REL, ptu_pkg::PTU_CALL_IND: begin
                            d.sp        = q.sp - ptu_pkg::WORD_STEP;
                            d.stk_addr  = phys(q.ss, q.sp - ptu_pkg::WORD_STEP);
                            d.stk_wdata = nip;
                            d.stk_we    = 1'b1;
                            d.stk_req   = 1'b1;
                            d.busy      = 1'b1;
                            d.st        = ptu_pkg::PTU_PUSH_IP;
                        end
                        ptu_pkg::PTU_RET_NEAR, ptu_pkg::PTU_RET_FAR: begin
                            d.stk_addr = phys(q.ss, q.sp);
                            d.stk_we   = 1'b0;
                            d.stk_req  = 1'b1;
                            d.busy     = 1'b1;
                            d.st       = ptu_pkg::PTU_POP_IP;
                        end
                        ptu_pkg::PTU_JMP_SHORT, ptu_pkg::PTU_JMP_NEAR, ptu_pkg::PTU_JMP_IND,
                        ptu_pkg::PTU_JMP_FAR, ptu_pkg::PTU_JMP_FIND: begin
                            fin    = 1'b1;
                            fin_ip = d.tgt_ip;
                            fin_cs = d.tgt_cs;
                        end
                        ptu_pkg::PTU_JCC: begin
                            if (go_cond > ptu_pkg::COND_LAST) begin
                                d.err = 1'b1;
                                d.ip  = q.ip;
                            end else if (cond_ok(go_cond, q.flags)) begin
                                fin    = 1'b1;
                                fin_ip = d.tgt_ip;
                                fin_cs = q.cs;
                            end
                        end
                        ptu_pkg::PTU_NOP: begin
                            d.ip = q.ip;
                        end
                        default: begin
                            d.err = 1'b1;
                            d.ip  = q.ip;
                        end
                    endcase
                end
            end
            ptu_pkg::PTU_PUSH_CS: begin
                if (stk_ack) begin
                    d.cs        = q.tgt_cs;
                    d.sp        = q.sp - ptu_pkg::WORD_STEP;
                    d.stk_addr  = phys(q.ss, q.sp - ptu_pkg::WORD_STEP);
                    d.stk_wdata = q.ip;
                    d.st        = ptu_pkg::PTU_PUSH_IP;
                end
            end
            ptu_pkg::PTU_PUSH_IP: begin
                if (stk_ack) begin
                    d.stk_req = 1'b0;
                    fin       = 1'b1;
                    fin_ip    = q.tgt_ip;
                    fin_cs    = q.cs;
                end
            end
            ptu_pkg::PTU_POP_IP: begin
                if (stk_ack) begin
                    if (q.cmd == ptu_pkg::PTU_RET_FAR) begin
                        d.ip       = stk_rdata;
                        d.sp       = q.sp + ptu_pkg::WORD_STEP;
                        d.stk_addr = phys(q.ss, q.sp + ptu_pkg::WORD_STEP);
                        d.st       = ptu_pkg::PTU_POP_CS;
                    end else begin
                        d.stk_req = 1'b0;
                        d.sp      = q.sp + ptu_pkg::WORD_STEP + q.popv;
                        fin       = 1'b1;
                        fin_ip    = stk_rdata;
                        fin_cs    = q.cs;
                    end
                end
            end
            ptu_pkg::PTU_POP_CS: begin
                if (stk_ack) begin
                    d.stk_req = 1'b0;
                    d.sp      = q.sp + ptu_pkg::WORD_STEP + q.popv;
                    fin       = 1'b1;
                    fin_ip    = q.ip;
                    fin_cs    = stk_rdata;
                end
            end
            default: begin
                d.st      = ptu_pkg::PTU_IDLE;
                d.stk_req = 1'b0;
                d.busy    = 1'b0;
            end
        endcase
        // Completion: new fetch address and queue flush
        if (fin) begin
            d.ip         = fin_ip;
            d.cs         = fin_cs;
            d.taken      = 1'b1;
            d.busy       = 1'b0;
            d.st         = ptu_pkg::PTU_IDLE;
            d.flush      = 1'b1;
            d.fetch_addr = phys(fin_cs, fin_ip);
        end
    end

    // ==================================================================
    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q        <= '0;
            q.st     <= ptu_pkg::PTU_IDLE;
            q.cmd    <= ptu_pkg::PTU_NOP;
            q.ip     <= ptu_pkg::IP_RST;
            q.cs     <= ptu_pkg::CS_RST;
            q.sp     <= ptu_pkg::SP_RST;
            q.ss     <= ptu_pkg::SS_RST;
        end else if (ce) begin
            q <= d;
        end
    end

    // Outputs straight from the state register
    assign prdata     = q.prdata;
    assign pready     = q.pready;
    assign pslverr    = q.pslverr;
    assign stk_req    = q.stk_req;
    assign stk_we     = q.stk_we;
    assign stk_addr   = q.stk_addr;
    assign stk_wdata  = q.stk_wdata;
    assign flush      = q.flush;
    assign fetch_addr = q.fetch_addr;
    assign busy       = q.busy;

    // ==================================================================
    // Assertions
    property p_stack_addr;
        @(posedge clk) disable iff (!rst_n)
        stk_req |-> stk_addr == phys(q.ss, q.sp);
    endproperty
    a_stack_addr: assert property (p_stack_addr) else $error("stack address not at pointer");

    property p_near_call_push;
        @(posedge clk) disable iff (!rst_n)
        ce && go && !q.busy && go_cmd == ptu_pkg::PTU_CALL_REL
        |=> q.sp == $past(q.sp) - 16'h0002 && stk_we && stk_wdata == $past(nip);
    endproperty
    a_near_call_push: assert property (p_near_call_push) else $error("near call push wrong");

    property p_saved_next;
        @(posedge clk) disable iff (!rst_n)
        q.st == ptu_pkg::PTU_PUSH_IP |-> stk_wdata == q.ip;
    endproperty
    a_saved_next: assert property (p_saved_next) else $error("saved pointer not next");

    property p_ret_pop;
        @(posedge clk) disable iff (!rst_n)
        ce && q.st == ptu_pkg::PTU_POP_IP && stk_ack
        |=> q.ip == $past(stk_rdata);
    endproperty
    a_ret_pop: assert property (p_ret_pop) else $error("return pointer not popped");

    property p_far_ret_seg;
        @(posedge clk) disable iff (!rst_n)
        ce && q.st == ptu_pkg::PTU_POP_CS && stk_ack
        |=> q.cs == $past(stk_rdata) && q.sp == $past(q.sp) + 16'h0002 + $past(q.popv);
    endproperty
    a_far_ret_seg: assert property (p_far_ret_seg) else $error("far return wrong");

    property p_pop_value;
        @(posedge clk) disable iff (!rst_n)
        ce && q.st == ptu_pkg::PTU_POP_IP && stk_ack && q.cmd == ptu_pkg::PTU_RET_NEAR
        |=> q.sp == $past(q.sp) + 16'h0002 + $past(q.popv);
    endproperty
    a_pop_value: assert property (p_pop_value) else $error("pop value not applied");

    property p_jump_no_stack;
        @(posedge clk) disable iff (!rst_n)
        ce && go && !q.busy && go_cmd >= ptu_pkg::PTU_JMP_SHORT
        |=> $stable(q.sp) && !stk_req && !busy;
    endproperty
    a_jump_no_stack: assert property (p_jump_no_stack) else $error("jump touched stack");

    property p_cond_fall;
        @(posedge clk) disable iff (!rst_n)
        ce && go && !q.busy && go_cmd == ptu_pkg::PTU_JCC && go_cond <= ptu_pkg::COND_LAST
        && !cond_ok(go_cond, q.flags) |=> q.ip == $past(nip) && !flush;
    endproperty
    a_cond_fall: assert property (p_cond_fall) else $error("false condition jumped");

    property p_flush_addr;
        @(posedge clk) disable iff (!rst_n)
        flush |-> fetch_addr == phys(q.cs, q.ip) && !busy;
    endproperty
    a_flush_addr: assert property (p_flush_addr) else $error("flush address wrong");

    property p_flags_kept;
        @(posedge clk) disable iff (!rst_n)
        q.busy |=> $stable(q.flags);
    endproperty
    a_flags_kept: assert property (p_flags_kept) else $error("flags changed in transfer");
endmodule : ptu_program_transfer

// *** tb/ptu_biu_model.sv ***
/* Stack memory model of the bus interface unit.
 Same clock as the unit; each request is acked after 0 to 3 idle cycles. */
`timescale 1ns/1ps
module ptu_biu_model (
    input  wire logic        clk,
    input  wire logic        stk_req,
    input  wire logic        stk_we,
    input  wire logic [19:0] stk_addr,
    input  wire logic [15:0] stk_wdata,
    output logic      [15:0] stk_rdata = 16'h0,
    output logic             stk_ack = 1'h0
);
    logic [15:0] mem [logic [19:0]];
    int          w = 0;
    int          seed = 15;
    // One-cycle ack; data line toggles except when answering a read
    always @(posedge clk) begin
        stk_ack <= 1'h0;
        stk_rdata <= ~stk_rdata;
        if (stk_req && !stk_ack && w == 0) begin
            stk_ack <= 1'h1;
            w = {$random(seed)} % 4;
            if (stk_we) mem[stk_addr] = stk_wdata;
            else stk_rdata <= mem[stk_addr];
        end else if (stk_req && !stk_ack) w--;
    end
endmodule : ptu_biu_model

// *** tb/tb_top.sv ***
/* Self-checking bench of the program transfer unit, driven over APB.
 Assumes the stack model answers every request. */
`timescale 1ns/1ps
module tb_top;
    logic        clk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [7:0]  paddr = 8'h0, d;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic        pready, pslverr, stk_req, stk_we, stk_ack, flush, busy;
    logic [19:0] stk_addr, fetch_addr;
    logic [15:0] stk_wdata, stk_rdata, ip;
    logic [4:0]  f;
    logic        pe;
    int          err_count = 0, checks_done = 0, seed = 15;
    ptu_program_transfer dut (.clk, .rst_n, .ce(1'h1), .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .stk_req, .stk_we, .stk_addr, .stk_wdata,
        .stk_rdata, .stk_ack, .flush, .fetch_addr, .busy);
    ptu_biu_model biu (.clk, .stk_req, .stk_we, .stk_addr, .stk_wdata, .stk_rdata, .stk_ack);
    // ==================================================================
    // Clock and shared tasks
    initial forever #10 clk = ~clk;
    task automatic end_of_test;
        $display("mismatches %0d checks %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_of_test
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        checks_done++;
        if (s !== e) begin
            $display("BAD %s exp %h got %h", nm, e, s);
            err_count++;
        end
    endtask : chk
    // Waits up to lim edges for pready during an APB transfer, otherwise for a low busy
    task automatic idle(input int lim);
        int n = 0;
        do begin
            @(posedge clk);
            n++;
        end while ((psel ? pready : busy) !== psel && n < lim);
        if (n >= lim) begin
            err_count++;
            end_of_test();
        end
    endtask : idle
    // One APB transfer; read data lands in r
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge clk);
        penable <= 1'h1;
        idle(20);
        r = prdata;
        pe = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb
    task automatic xfer(input logic [15:0] c);
        apb(1'h1, ptu_pkg::OFS_CMD, {16'h0, c});
        idle(60);
    endtask : xfer
    task automatic regs(input logic [15:0] i, input logic [15:0] c, input logic [15:0] s);
        apb(1'h0, ptu_pkg::OFS_IP, 32'h0);
        chk("ip", {16'h0, i}, r);
        apb(1'h0, ptu_pkg::OFS_CS, 32'h0);
        chk("cs", {16'h0, c}, r);
        apb(1'h0, ptu_pkg::OFS_SP, 32'h0);
        chk("sp", {16'h0, s}, r);
        chk("fetch", {12'h0, c, 4'h0} + {16'h0, i}, {12'h0, fetch_addr});
    endtask : regs
    // Expected outcome of each condition code
    function automatic logic cond_true(input logic [4:0] c, input logic [4:0] g);
        logic [17:0] t;
        logic        cy, z, s, o, p;
        {p, o, s, z, cy} = g;
        t = {s, p, o, !s, !p, !o, !z, !cy, (s ^ o) | z, s ^ o, !(s ^ o), !((s ^ o) | z),
            z, cy, cy | z, cy, !cy, !(cy | z)};
        return t[c];
    endfunction : cond_true
    // ==================================================================
    // Main sequence
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'h1;
        for (int c = 0; c <= 17; c++) begin
            f = 5'($random(seed));
            d = (c == 0) ? 8'h80 : (c == 1) ? 8'h00 : 8'($random(seed));
            ip = 16'($random(seed));
            apb(1'h1, ptu_pkg::OFS_FLAGS, {27'h0, f});
            apb(1'h1, ptu_pkg::OFS_IP, {16'h0, ip});
            apb(1'h1, ptu_pkg::OFS_OPA, {24'h0, d});
            xfer({4'h2, 3'h0, 5'(c), 4'hc});
            apb(1'h0, ptu_pkg::OFS_IP, 32'h0);
            chk("cond", {16'h0, ip + 16'h2 + (cond_true(5'(c), f) ? {{8{d[7]}}, d} : 16'h0)}, r);
            apb(1'h0, ptu_pkg::OFS_FLAGS, 32'h0);
            chk("flags", {27'h0, f}, r);
        end
        // Near call back by sixteen, return discarding four bytes
        apb(1'h1, ptu_pkg::OFS_SS, 32'h0000_1234);
        apb(1'h1, ptu_pkg::OFS_SP, 32'h0000_0100);
        apb(1'h1, ptu_pkg::OFS_IP, 32'h0000_1000);
        apb(1'h1, ptu_pkg::OFS_OPA, 32'h0000_fff0);
        xfer(16'h3001);
        regs(16'h0ff3, 16'h0000, 16'h00fe);
        apb(1'h1, ptu_pkg::OFS_POPV, 32'h0000_0004);
        xfer(16'h1005);
        regs(16'h1003, 16'h0000, 16'h0104);
        // Far call and far return, then far jump
        apb(1'h1, ptu_pkg::OFS_CS, 32'h0000_4000);
        apb(1'h1, ptu_pkg::OFS_IP, 32'h0000_2000);
        apb(1'h1, ptu_pkg::OFS_OPA, 32'h0000_0abc);
        apb(1'h1, ptu_pkg::OFS_OPB, 32'h0000_5000);
        apb(1'h1, ptu_pkg::OFS_POPV, 32'h0000_0000);
        xfer(16'h5003);
        regs(16'h0abc, 16'h5000, 16'h0100);
        xfer(16'h1006);
        regs(16'h2005, 16'h4000, 16'h0104);
        xfer(16'h500a);
        regs(16'h0abc, 16'h5000, 16'h0104);
        // Short, near and indirect jumps, indirect calls and their returns
        apb(1'h1, ptu_pkg::OFS_OPA, 32'h0000_0f80);
        xfer(16'h2007);
        regs(16'h0a3e, 16'h5000, 16'h0104);
        xfer(16'h3008);
        regs(16'h19c1, 16'h5000, 16'h0104);
        xfer(16'h2009);
        regs(16'h0f80, 16'h5000, 16'h0104);
        apb(1'h1, ptu_pkg::OFS_OPB, 32'h0000_6000);
        xfer(16'h400b);
        regs(16'h0f80, 16'h6000, 16'h0104);
        xfer(16'h3002);
        regs(16'h0f80, 16'h6000, 16'h0102);
        xfer(16'h4004);
        regs(16'h0f80, 16'h6000, 16'h00fe);
        xfer(16'h1006);
        regs(16'h0f84, 16'h6000, 16'h0102);
        xfer(16'h1005);
        regs(16'h0f83, 16'h6000, 16'h0104);
        apb(1'h0, ptu_pkg::OFS_STATUS, 32'h0);
        chk("status", 32'h0000_0002, r);
        // Refused write and unknown command
        apb(1'h1, ptu_pkg::OFS_STATUS, 32'h0);
        chk("pslverr", 32'h0000_0001, {31'h0, pe});
        xfer(16'h000f);
        apb(1'h0, ptu_pkg::OFS_STATUS, 32'h0);
        chk("status", 32'h0000_0004, r);
        end_of_test();
    end
endmodule : tb_top
